//--- ccs_regs.svh
// Timing constants for the clock compensation scheduler
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH
`define CCS_PERIOD_2B 5000
`define CCS_RUN_2B 6
`define CCS_PERIOD_4B 3000
`define CCS_RUN_4B 3
`define CCS_WARN_BASE 3
`define CCS_WARN_MAX_2B 10
`define CCS_WARN_MAX_4B 6
`define CCS_MIN_RUN 2
`define CCS_MIN_GAP 8
`define CCS_MAX_RUN 12
`endif

//--- ccs_pkg.sv
// Types shared by the scheduler and the link-core end
package ccs_pkg;
  typedef enum logic [1:0] {
    CCS_IDLE = 2'b00,
    CCS_COUNT = 2'b01,
    CCS_WARN = 2'b10,
    CCS_BURST = 2'b11
  } ccs_state_t;

  // Warning lead time for a lane width and largest message size
  function automatic int ccs_lead(input int lane_bytes, input int msg_bytes);
    int lead;
    lead = 3;
    if (lane_bytes < 16 && msg_bytes > lane_bytes) begin
      lead = 3 + (msg_bytes - 1) / lane_bytes;
    end
    return lead;
  endfunction
endpackage

//--- ccs_link_if.sv
// Compensation link between scheduler and link core
`timescale 1ns/1ns
`default_nettype none
interface ccs_link_if;
  logic comp_request;
  logic comp_warning;
  logic link_up;
  modport sched (output comp_request, output comp_warning, input link_up);
  modport core (input comp_request, input comp_warning, output link_up);
endinterface
`default_nettype wire

//--- ccs_down_counter.sv
// Loadable down counter with zero flag
`timescale 1ns/1ns
`default_nettype none
module ccs_down_counter #(
  parameter int W = 13
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic zero_o
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  wire is_zero = (cnt_r == '0);
  assign cnt_nxt = load_i ? value_i : (is_zero ? cnt_r : cnt_r - {{(W-1){1'b0}}, 1'b1});
  assign zero_o = is_zero;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

//--- ccs_scheduler.sv
// Periodic clock compensation scheduler
`timescale 1ns/1ns
`default_nettype none
`include "ccs_regs.svh"
// Behaviour
// - Hold request a fixed run each period
// - 2-byte: 5000/6; 4-byte: 3000/3
// - Core sends compensation while request high
// - Core drops TREADY while request high
// - Warning precedes request; core blocks messages
// - 2-byte lead: 3 plus one per 2 bytes
// - Wider lanes shorten lead toward 3
// - Core refuses native messages during warning/request
// - Warning only matters with flow control
// - Lead sized for largest message
// - Shared clock: tie both outputs low
// - Core accepts any request timing
// - Bursts at least two cycles
// - Bursts at least eight cycles apart
// - Bursts no longer than twelve cycles
// - First request PER_C+3 cycles after link-up
// - Link-up from core channel-up output
module ccs_scheduler import ccs_pkg::*; #(
  parameter int LANE_BYTES = 2,
  parameter int MAX_MSG_BYTES = 16,
  parameter int USE_WARNING = 1,
  parameter int PERIOD = (LANE_BYTES == 2) ? `CCS_PERIOD_2B : `CCS_PERIOD_4B,
  parameter int RUN = (LANE_BYTES == 2) ? `CCS_RUN_2B : `CCS_RUN_4B
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  ccs_link_if.sched link,
  output logic busy_o
);
  localparam int LEAD = ccs_lead(LANE_BYTES, MAX_MSG_BYTES);
  localparam int RUN_C = (RUN < `CCS_MIN_RUN) ? `CCS_MIN_RUN :
                         ((RUN > `CCS_MAX_RUN) ? `CCS_MAX_RUN : RUN);
  localparam int PER_C = (PERIOD < RUN_C + `CCS_MIN_GAP + LEAD) ?
                         (RUN_C + `CCS_MIN_GAP + LEAD) : PERIOD;
  localparam int W = $clog2(PER_C + 1);
  localparam logic [W-1:0] GAP_LD = W'(PER_C - LEAD - 1);
  localparam logic [W-1:0] LEAD_LD = W'(LEAD - 1);
  localparam logic [W-1:0] RUN_LD = W'(RUN_C - 1);

  ccs_state_t state_r, state_nxt;
  logic up_s1_r, up_s2_r;
  logic req_r, warn_r, busy_r;
  logic load, zero;
  logic [W-1:0] load_val;

  ccs_down_counter #(.W(W)) u_cnt (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .load_i(load),
    .value_i(load_val),
    .zero_o(zero)
  );

  wire up = up_s2_r;
  wire enter_count = (state_r == CCS_IDLE) && up;
  wire end_count = (state_r == CCS_COUNT) && zero;
  wire end_warn = (state_r == CCS_WARN) && zero;
  wire end_burst = (state_r == CCS_BURST) && zero;
  assign load = enter_count || end_count || end_warn || end_burst || !up;
  assign load_val = !up ? '0 : (end_count ? LEAD_LD : (end_warn ? RUN_LD : GAP_LD));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CCS_IDLE: begin
        if (up) begin
          state_nxt = CCS_COUNT;
        end
      end
      CCS_COUNT: begin
        if (zero) begin
          state_nxt = CCS_WARN;
        end
      end
      CCS_WARN: begin
        if (zero) begin
          state_nxt = CCS_BURST;
        end
      end
      CCS_BURST: begin
        if (zero) begin
          state_nxt = CCS_COUNT;
        end
      end
      default: state_nxt = CCS_IDLE;
    endcase
    if (!up) begin
      state_nxt = CCS_IDLE;
    end
  end

  wire req_nxt = (state_nxt == CCS_BURST);
  wire warn_nxt = (USE_WARNING != 0) &&
                  (state_nxt == CCS_WARN || state_nxt == CCS_BURST);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= CCS_IDLE;
      up_s1_r <= 1'b0;
      up_s2_r <= 1'b0;
      req_r <= 1'b0;
      warn_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      up_s1_r <= link.link_up;
      up_s2_r <= up_s1_r;
      req_r <= req_nxt;
      warn_r <= warn_nxt;
      busy_r <= warn_nxt || req_nxt;
    end
  end

  assign link.comp_request = req_r;
  assign link.comp_warning = warn_r;
  assign busy_o = busy_r;
endmodule
`default_nettype wire

//--- ccs_core_end.sv
// Link-core end of the compensation interface
`timescale 1ns/1ns
`default_nettype none
module ccs_core_end import ccs_pkg::*; (
  input wire logic mclk_i,
  input wire logic rst_i,
  ccs_link_if.core link,
  input wire logic channel_up_i,
  input wire logic tx_valid_i,
  input wire logic user_msg_req_i,
  input wire logic native_msg_req_i,
  output logic tx_ready_o,
  output logic user_msg_ack_o,
  output logic native_msg_ack_o,
  output logic comp_send_o
);
  logic up_r, ready_r, uack_r, nack_r, send_r;
  wire req_eff = link.comp_request && up_r;
  wire block = link.comp_warning || link.comp_request;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      up_r <= 1'b0;
      ready_r <= 1'b0;
      uack_r <= 1'b0;
      nack_r <= 1'b0;
      send_r <= 1'b0;
    end else begin
      up_r <= channel_up_i;
      send_r <= req_eff;
      ready_r <= up_r && !req_eff && tx_valid_i;
      uack_r <= up_r && user_msg_req_i && !block;
      nack_r <= up_r && native_msg_req_i && !block;
    end
  end
  assign link.link_up = up_r;
  assign tx_ready_o = ready_r;
  assign user_msg_ack_o = uack_r;
  assign native_msg_ack_o = nack_r;
  assign comp_send_o = send_r;
endmodule
`default_nettype wire

//--- ccs_link_chk.sv
// Assertions on the compensation link
`timescale 1ns/1ns
`default_nettype none
module ccs_link_chk #(
  parameter int PERIOD = 40
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic comp_request,
  input wire logic comp_warning,
  input wire logic link_up
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_burst; comp_request[*6] ##1 !comp_request; endsequence
  sequence s_lead; ((comp_warning && !comp_request) || !link_up)[*8]; endsequence
  chk_run_len: assert property ($rose(comp_request) |-> s_burst)
    else $error("request run length wrong");
  chk_lead_time: assert property ($rose(comp_request) |-> $past(comp_warning, 10) && !$past(comp_warning, 11))
    else $error("warning lead wrong");
  chk_warn_first: assert property (comp_request |-> comp_warning)
    else $error("request without warning");
  chk_warn_quiet: assert property ($rose(comp_warning) |-> s_lead)
    else $error("request too soon after warning");
  chk_fall_together: assert property ($fell(comp_warning) |-> $fell(comp_request) || !$past(link_up, 3))
    else $error("warning and request fall apart");
  chk_burst_gap: assert property ($fell(comp_request) |-> !comp_request[*8])
    else $error("bursts too close");
  chk_link_down: assert property (!link_up[*4] |-> !comp_warning && !comp_request)
    else $error("outputs high while link down");
  chk_period: assert property ($fell(comp_request) |-> ##[1:PERIOD] (comp_warning || !link_up))
    else $error("next warning late");
endmodule
`default_nettype wire

//--- clock_comp_scheduler_tb_top.sv
// Testbench for scheduler and link-core end
`timescale 1ns/1ns
`default_nettype none
module clock_comp_scheduler_tb_top;
  logic mclk_i = 1'b0, rst_i = 1'b1, chup = 1'b0, txv = 1'b1, ureq = 1'b1, nreq = 1'b1;
  logic tx_ready, uack, nack, csend, busy;
  int fail_count = 0, n_checks = 0;
  ccs_link_if link ();
  ccs_scheduler #(.PERIOD(40)) ccs_scheduler_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(link),
    .busy_o(busy));
  ccs_core_end ccs_core_end_i (.mclk_i(mclk_i), .rst_i(rst_i), .link(link), .channel_up_i(chup),
    .tx_valid_i(txv), .user_msg_req_i(ureq), .native_msg_req_i(nreq), .tx_ready_o(tx_ready),
    .user_msg_ack_o(uack), .native_msg_ack_o(nack), .comp_send_o(csend));
  ccs_link_chk #(.PERIOD(40)) ccs_link_chk_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .comp_request(link.comp_request), .comp_warning(link.comp_warning), .link_up(link.link_up));
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d fails=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_warn();
    int n;
    n = 0;
    while (link.comp_warning !== 1'b1) begin
      @(negedge mclk_i);
      n++;
      if (n > 100) begin
        fail_count++;
        test_done();
      end
    end
  endtask
  task automatic t_burst();
    int n;
    wait_warn();
    n = 0;
    while (link.comp_request !== 1'b1 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    cmp(16'(n), 16'h000a);
    @(negedge mclk_i);
    cmp({tx_ready, uack, nack, csend, busy}, 16'h0003);
    n = 1;
    while (link.comp_request === 1'b1 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    cmp(16'(n), 16'h0006);
    cmp(link.comp_warning, 16'h0000);
    @(negedge mclk_i);
    cmp({tx_ready, uack, nack, csend, busy}, 16'h001c);
  endtask
  task automatic t_drop();
    wait_warn();
    chup = 1'b0;
    repeat (5) @(negedge mclk_i);
    repeat (40) begin
      cmp({link.comp_warning, link.comp_request}, 16'h0000);
      @(negedge mclk_i);
    end
    chup = 1'b1;
  endtask
  initial begin
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    chup = 1'b1;
    t_burst();
    t_burst();
    t_drop();
    t_burst();
    test_done();
  end
endmodule
`default_nettype wire
